// *** src/extended_interrupt_mask_bank.sv ***
// Extended interrupt mask register with per-source request gating.
// Assumes a single-cycle register bus and same-clock peripheral flags.
// How it works
// R1: Bit 7 gates both timer-three overflow flags.
// R2: Bit 6 gates comparator B edge flags.
// R3: Bit 5 gates comparator A edge flags.
// R4: Bit 4 gates all counter-array requests.
// R5: Bit 2 gates the window-compare request.
// R6: Bits 3,0 gate; bit 1 reserved; reset zero.
`include "irq_mask_map.svh"
module extended_interrupt_mask_bank (
  input wire logic mclk,
  input wire logic reset_n,
  input wire irq_mask_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  input wire irq_mask_pkg::irq_src_t irq_src,
  output logic [7:0] irq_out
);
  import irq_mask_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Declarations.

  // The mask register itself; bit 1 never leaves zero.
  logic [7:0] extended_interrupt_enable_one_r;
  // Read data flip-flop, loaded in the cycle that follows a read.
  logic [7:0] rdata_r;
  // Merged request per mask bit, ahead of the gate.
  logic [7:0] req_vec;
  // Enable per mask bit, rebuilt from the named fields.
  logic [7:0] en_vec;
  // Bus decode for the current cycle.
  logic sel;
  logic wr_hit;
  logic rd_hit;
  // Named enable fields of the mask register, one per gated source.
  logic timer_three_irq_enable;
  logic comparator_b_irq_enable;
  logic comparator_a_irq_enable;
  logic counter_array_irq_enable;
  logic conversion_done_irq_enable;
  logic window_compare_irq_enable;
  logic two_wire_bus_irq_enable;

  ////////////////////////////////////////////////////////////////////
  // Register access.

  // Only the one mapped address is decoded; any other address is ignored.
  assign sel = (sfr_req.addr == `MASK_REG_ADDR);
  assign wr_hit = sfr_req.wr && sel;
  assign rd_hit = sfr_req.rd && sel;

  // Write stores all bits but the reserved one, which stays zero.
  // A read in the same cycle still returns the value from before the write.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      extended_interrupt_enable_one_r <= `MASK_REG_RESET; // [R6]
    end else if (wr_hit) begin
      extended_interrupt_enable_one_r <= sfr_req.wdata & `MASK_WRITABLE; // [R6]
    end
  end

  // Read data stands for one cycle after a read, then falls back to zero.
  // Zero outside a read keeps the bus quiet while other registers answer.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= `READ_IDLE;
    end else if (rd_hit) begin
      rdata_r <= extended_interrupt_enable_one_r; // [R6]
    end else begin
      rdata_r <= `READ_IDLE;
    end
  end

  // Read data leaves the block straight from its flip-flop.
  assign sfr_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////
  // Enable fields.

  // Each field is one bit of the mask register, named after what it gates.
  assign timer_three_irq_enable =
    extended_interrupt_enable_one_r[`BIT_TIMER_THREE]; // [R1]
  assign comparator_b_irq_enable =
    extended_interrupt_enable_one_r[`BIT_COMPARATOR_B]; // [R2]
  assign comparator_a_irq_enable =
    extended_interrupt_enable_one_r[`BIT_COMPARATOR_A]; // [R3]
  assign counter_array_irq_enable =
    extended_interrupt_enable_one_r[`BIT_COUNTER_ARRAY]; // [R4]
  assign conversion_done_irq_enable =
    extended_interrupt_enable_one_r[`BIT_CONVERSION_DONE]; // [R6]
  assign window_compare_irq_enable =
    extended_interrupt_enable_one_r[`BIT_WINDOW_COMPARE]; // [R5]
  assign two_wire_bus_irq_enable =
    extended_interrupt_enable_one_r[`BIT_TWO_WIRE_BUS]; // [R6]

  // Enable vector rebuilt field by field; the reserved position stays low.
  always_comb begin
    en_vec = 8'h00;
    en_vec[`BIT_TIMER_THREE] = timer_three_irq_enable; // [R1]
    en_vec[`BIT_COMPARATOR_B] = comparator_b_irq_enable; // [R2]
    en_vec[`BIT_COMPARATOR_A] = comparator_a_irq_enable; // [R3]
    en_vec[`BIT_COUNTER_ARRAY] = counter_array_irq_enable; // [R4]
    en_vec[`BIT_CONVERSION_DONE] = conversion_done_irq_enable; // [R6]
    en_vec[`BIT_WINDOW_COMPARE] = window_compare_irq_enable; // [R5]
    en_vec[`BIT_TWO_WIRE_BUS] = two_wire_bus_irq_enable; // [R6]
  end

  ////////////////////////////////////////////////////////////////////
  // Request gating.

  // Flags merged per mask bit; timer and comparators each OR two flags.
  always_comb begin
    req_vec = 8'h00;
    req_vec[`BIT_TIMER_THREE] = irq_src.timer_three_low_overflow_flag
                              | irq_src.timer_three_high_overflow_flag; // [R1]
    req_vec[`BIT_COMPARATOR_B] = irq_src.comparator_b_rise_flag
                               | irq_src.comparator_b_fall_flag; // [R2]
    req_vec[`BIT_COMPARATOR_A] = irq_src.comparator_a_rise_flag
                               | irq_src.comparator_a_fall_flag; // [R3]
    req_vec[`BIT_COUNTER_ARRAY] = irq_src.counter_array; // [R4]
    req_vec[`BIT_CONVERSION_DONE] = irq_src.conversion_done; // [R6]
    req_vec[`BIT_WINDOW_COMPARE] = irq_src.window_compare_flag; // [R5]
    req_vec[`BIT_TWO_WIRE_BUS] = irq_src.two_wire_bus; // [R6]
  end

  // Gated requests toward the core's interrupt logic.
  irq_gate #(.WIDTH(8)) u_gate (
    .req(req_vec),
    .en(en_vec),
    .gated(irq_out)
  );

  ////////////////////////////////////////////////////////////////////
  // Checks on the gating.

  // Timer three passes either overflow flag only while enabled.
  AST_T3: assert property (@(posedge mclk) disable iff (!reset_n) // [R1]
    irq_out[`BIT_TIMER_THREE] == (extended_interrupt_enable_one_r[`BIT_TIMER_THREE]
      && (irq_src.timer_three_low_overflow_flag
      || irq_src.timer_three_high_overflow_flag)))
    else $error("Timer three gating wrong.");

  // Comparator B passes either edge flag only while enabled.
  AST_CPB: assert property (@(posedge mclk) disable iff (!reset_n) // [R2]
    irq_out[`BIT_COMPARATOR_B] == (extended_interrupt_enable_one_r[`BIT_COMPARATOR_B]
      && (irq_src.comparator_b_rise_flag || irq_src.comparator_b_fall_flag)))
    else $error("Comparator B gating wrong.");

  // Comparator A passes either edge flag only while enabled.
  AST_CPA: assert property (@(posedge mclk) disable iff (!reset_n) // [R3]
    irq_out[`BIT_COMPARATOR_A] == (extended_interrupt_enable_one_r[`BIT_COMPARATOR_A]
      && (irq_src.comparator_a_rise_flag || irq_src.comparator_a_fall_flag)))
    else $error("Comparator A gating wrong.");

  // The counter array request passes only while enabled.
  AST_CNT: assert property (@(posedge mclk) disable iff (!reset_n) // [R4]
    irq_out[`BIT_COUNTER_ARRAY] == (extended_interrupt_enable_one_r[`BIT_COUNTER_ARRAY]
      && irq_src.counter_array))
    else $error("Counter array gating wrong.");

  // The window-compare request passes only while enabled.
  AST_WIN: assert property (@(posedge mclk) disable iff (!reset_n) // [R5]
    irq_out[`BIT_WINDOW_COMPARE] == (extended_interrupt_enable_one_r[`BIT_WINDOW_COMPARE]
      && irq_src.window_compare_flag))
    else $error("Window compare gating wrong.");

  // The conversion-done request passes only while enabled.
  AST_CONV: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
    irq_out[`BIT_CONVERSION_DONE] == (extended_interrupt_enable_one_r[`BIT_CONVERSION_DONE]
      && irq_src.conversion_done))
    else $error("Conversion done gating wrong.");

  // The two-wire bus request passes only while enabled.
  AST_TWB: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
    irq_out[`BIT_TWO_WIRE_BUS] == (extended_interrupt_enable_one_r[`BIT_TWO_WIRE_BUS]
      && irq_src.two_wire_bus))
    else $error("Two wire bus gating wrong.");

  ////////////////////////////////////////////////////////////////////
  // Checks on the register.

  // The reserved bit is never stored and never raises a request.
  AST_RSV: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
    !extended_interrupt_enable_one_r[`BIT_RESERVED] && !irq_out[`BIT_RESERVED])
    else $error("Reserved bit set.");

  // The reserved bit always reads back as zero.
  AST_RSV_RD: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
    !sfr_rdata[`BIT_RESERVED])
    else $error("Reserved bit read as one.");

  // A write to the mapped address lands in the next cycle.
  AST_WR: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
    (sfr_req.wr && sfr_req.addr == `MASK_REG_ADDR)
      |=> extended_interrupt_enable_one_r == ($past(sfr_req.wdata) & `MASK_WRITABLE))
    else $error("Write not stored.");

  // A read returns the value held in the cycle of the read.
  AST_RD: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
    (sfr_req.rd && sfr_req.addr == `MASK_REG_ADDR)
      |=> sfr_rdata == $past(extended_interrupt_enable_one_r))
    else $error("Read data wrong.");

  // Without a read of the mapped address the read data is zero.
  AST_RD_IDLE: assert property (@(posedge mclk) disable iff (!reset_n) // [R6]
    !(sfr_req.rd && sfr_req.addr == `MASK_REG_ADDR)
      |=> sfr_rdata == `READ_IDLE)
    else $error("Read data not idle.");

  // Reset clears the mask, so no request passes right after it.
  AST_RST: assert property (@(posedge mclk) // [R6]
    !reset_n |=> extended_interrupt_enable_one_r == `MASK_REG_RESET
      && irq_out == 8'h00)
    else $error("Reset did not clear the mask.");

  ////////////////////////////////////////////////////////////////////
  // Coverage of the main scenarios.

  // A write reaches the mask register.
  COV_WR: cover property (@(posedge mclk) disable iff (!reset_n) wr_hit);
  // A read of the mask register.
  COV_RD: cover property (@(posedge mclk) disable iff (!reset_n) rd_hit);
  // A read and a write meet in one cycle.
  COV_RDWR: cover property (@(posedge mclk) disable iff (!reset_n) rd_hit && wr_hit);
  // A timer-three request reaches the core.
  COV_T3: cover property (@(posedge mclk) disable iff (!reset_n) irq_out[`BIT_TIMER_THREE]);
  // A counter array request is held back by its mask.
  COV_BLK: cover property (@(posedge mclk) disable iff (!reset_n)
    irq_src.counter_array && !counter_array_irq_enable);
endmodule : extended_interrupt_mask_bank

// *** src/irq_mask_map.svh ***
// Register map constants for the extended interrupt mask bank.
// Assumes inclusion by bare name from the mask bank module file.
`ifndef IRQ_MASK_MAP_SVH
`define IRQ_MASK_MAP_SVH
`define MASK_REG_ADDR 8'hE6
`define MASK_REG_RESET 8'h00
`define BIT_TIMER_THREE 7
`define BIT_COMPARATOR_B 6
`define BIT_COMPARATOR_A 5
`define BIT_COUNTER_ARRAY 4
`define BIT_CONVERSION_DONE 3
`define BIT_WINDOW_COMPARE 2
`define BIT_RESERVED 1
`define BIT_TWO_WIRE_BUS 0
`define MASK_WRITABLE 8'hFD
`define READ_IDLE 8'h00
`endif

// *** src/irq_mask_pkg.sv ***
// Types shared by the interrupt mask bank files.
// Assumes the map header sits beside it on the include path.
package irq_mask_pkg;
  // Raw requests from the peripherals, one bit per flag.
  typedef struct packed {
    logic timer_three_low_overflow_flag;
    logic timer_three_high_overflow_flag;
    logic comparator_b_rise_flag;
    logic comparator_b_fall_flag;
    logic comparator_a_rise_flag;
    logic comparator_a_fall_flag;
    logic counter_array;
    logic conversion_done;
    logic window_compare_flag;
    logic two_wire_bus;
  } irq_src_t;
  // Special-function register bus request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
endpackage : irq_mask_pkg

// *** src/irq_gate.sv ***
// One gate per source group: request passes only while enabled.
// Assumes requests come from logic on the same clock.
module irq_gate #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] req,
  input wire logic [WIDTH-1:0] en,
  output logic [WIDTH-1:0] gated
);
  // Each output bit is its request qualified by its enable.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign gated[i] = req[i] & en[i];
  end
endmodule : irq_gate

// *** test/periph_model.sv ***
// Peripheral flag source facing the interrupt mask bank.
// Assumes the bench hands it a flag pattern at falling mclk.
module periph_model (
  input wire logic [9:0] pattern,
  output irq_mask_pkg::irq_src_t irq_src
);
  timeunit 1ns;
  timeprecision 1ps;
  import irq_mask_pkg::*;
  // Flags are levels on the bank's own clock, so they pass straight through.
  assign irq_src = irq_src_t'(pattern);
endmodule : periph_model

// *** test/testbench.sv ***
// Self-checking bench for the extended interrupt mask bank.
// Assumes the package, map header and design are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_mask_pkg::*;
  logic mclk = 0, reset_n = 0;
  sfr_req_t sfr_req = '0;
  logic [9:0] pattern = '0;
  logic [7:0] sfr_rdata, irq_out, m, mask;
  irq_src_t irq_src;
  int err_total = 0, n_tests = 0, seed = 6447, cyc = 0;
  always #4 mclk = ~mclk;
  extended_interrupt_mask_bank extended_interrupt_mask_bank_inst (.mclk(mclk),
    .reset_n(reset_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .irq_src(irq_src),
    .irq_out(irq_out));
  periph_model periph_model_inst (.pattern(pattern), .irq_src(irq_src));
  // Expected gated requests for a mask and a flag pattern.
  function automatic logic [7:0] gate(logic [7:0] k, logic [9:0] s);
    return {k[7] & (s[9] | s[8]), k[6] & (s[7] | s[6]), k[5] & (s[5] | s[4]),
      k[4] & s[3], k[3] & s[2], k[2] & s[1], 1'b0, k[0] & s[0]};
  endfunction : gate
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // One register access, strobe held for one clock.
  task automatic access(logic wr, logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    sfr_req = '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge mclk);
    sfr_req = '0;
  endtask : access
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  // Cuts a hang short.
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 5000) begin
      err_total++;
      stop_test();
    end
  end
  // Walks single enables, all ones and random masks against every flag.
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1;
    access(0, 8'hE6, 8'h00);
    check("reset mask", 8'h00, sfr_rdata);
    for (int i = 0; i < 40; i++) begin
      m = (i < 8) ? 8'h01 << i : (i == 8) ? 8'hFF : 8'($random(seed));
      access(1, 8'hE6, m);
      access(1, 8'h5A, ~m);
      access(0, 8'h5A, 8'h00);
      check("unmapped read", 8'h00, sfr_rdata);
      access(0, 8'hE6, 8'h00);
      mask = m & 8'hFD;
      check("mask read", mask, sfr_rdata);
      @(negedge mclk);
      check("read data idle", 8'h00, sfr_rdata);
      for (int j = 0; j < 14; j++) begin
        pattern = (j < 10) ? 10'h001 << j : 10'($random(seed));
        #1;
        check("irq_out", gate(mask, pattern), irq_out);
        @(negedge mclk);
      end
    end
    // Corner: all enables with all flags, then a read that meets a write.
    access(1, 8'hE6, 8'hFF);
    pattern = 10'h3FF;
    #1;
    check("irq_out all", 8'hFD, irq_out);
    @(negedge mclk);
    sfr_req = '{wr: 1'b1, rd: 1'b1, addr: 8'hE6, wdata: 8'h00};
    @(negedge mclk);
    sfr_req = '0;
    check("read during write", 8'hFD, sfr_rdata);
    check("irq_out masked", 8'h00, irq_out);
    access(1, 8'hE6, 8'hFF);
    check("irq_out before reset", 8'hFD, irq_out);
    reset_n = 0;
    @(negedge mclk);
    check("irq_out in reset", 8'h00, irq_out);
    reset_n = 1;
    access(0, 8'hE6, 8'h00);
    check("mask after reset", 8'h00, sfr_rdata);
    stop_test();
  end
endmodule : testbench
